// >>> common/rst_ctl_pkg.sv
package rst_ctl_pkg;

  // Register map (word index on the plain register port)
  localparam logic [7:0] STATUS_OFFSET    = 8'h03;  // processor_state_flags
  localparam logic [7:0] CONFIG_OFFSET    = 8'h10;  // device_configuration_word, read only
  localparam logic [7:0] CAUSE_OFFSET     = 8'h11;  // sticky event status, write one to clear
  localparam logic [7:0] MASK_OFFSET      = 8'h12;  // event interrupt mask
  localparam logic [7:0] CTRL_OFFSET      = 8'h13;  // bit0 sleep request, bit1 watchdog clear

  // Status register field positions
  localparam int STATUS_PAGE_LSB = 5;
  localparam int STATUS_TO_BIT   = 4;
  localparam int STATUS_PD_BIT   = 3;
  localparam logic [2:0] PAGE_RESET = 3'h0;

  // Configuration word field positions and fill
  localparam int CFG_OSC_LSB   = 0;
  localparam int CFG_WATCHDOG_ENABLE_BIT_BIT  = 2;
  localparam int CFG_CP_BIT    = 3;
  localparam logic [7:0] CFG_UNIMPL_FILL = 8'hFF;

  // Oscillator types
  localparam logic [1:0] OSC_LOW_POWER_CRYSTAL = 2'h0;
  localparam logic [1:0] OSC_STANDARD_CRYSTAL  = 2'h1;
  localparam logic [1:0] OSC_HIGH_SPEED_CRYSTAL = 2'h2;
  localparam logic [1:0] OSC_RESISTOR_CAPACITOR = 2'h3;

  // Event bits in cause / mask registers
  localparam int EV_POR       = 0;
  localparam int EV_MASTER_CLEAR_PIN_RUN  = 1;
  localparam int EV_MASTER_CLEAR_PIN_WAKE = 2;
  localparam int EV_WDT_RUN   = 3;
  localparam int EV_WDT_WAKE  = 4;
  localparam int EV_WIDTH     = 5;

  // Timing
  localparam int  CLK_HZ            = 25_000_000;
  localparam int  STARTUP_DELAY_MS  = 18;
  localparam int  STARTUP_CYCLES    = CLK_HZ / 1000 * STARTUP_DELAY_MS;
  localparam int  CLKOUT_DIVIDE     = 4;
  localparam int  WDT_PERIOD_TICKS  = 4096;

  // Reset cause kinds
  typedef enum logic [2:0] {
    CAUSE_POR, CAUSE_MASTER_CLEAR_PIN_RUN, CAUSE_MASTER_CLEAR_PIN_WAKE, CAUSE_WDT_RUN, CAUSE_WDT_WAKE
  } reset_cause_t;

  // Register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [11:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

endpackage

// >>> logic/reset_cause_and_config_control.sv
// Notes on behaviour
// R01: Five reset sources: power-on, pin, watchdog variants.
// R02: Cause flags encode which reset occurred.
// R03: Wake from sleep forces full reset.
// R04: Reset-independent registers survive all but power-on.
// R05: Other registers take reset state always; the cause and mask registers here take it on power-on only.
// R06: Status loads page zero and cause flags.
// R07: Only configuration bit disables watchdog.
// R08: Watchdog runs from its own RC tick.
// R09: Startup delay holds core in reset 18 ms.
// R10: Two configuration bits select oscillator type.
// R11: Code protect bit; upper configuration bits read one.
// R12: RC mode drives clock divided by four.
// R13: Sleep left only by pin or watchdog.
// R14: External party pulls pin low for reset.
// R15: Program counter starts at top of memory.
// R16: Pin and watchdog tick synchronised, held through delay.
// R17: Cause flags read only to software.
`timescale 1ns/100ps
`default_nettype none
module reset_cause_and_config_control
  import rst_ctl_pkg::*;
#(
  parameter int STARTUP_COUNT = STARTUP_CYCLES,
  parameter int WDT_TICKS     = WDT_PERIOD_TICKS,
  parameter int PC_WIDTH      = 11,
  parameter logic [11:0] CONFIG_WORD = 12'hFFF
) (
  // Clock and reset (sys_rst acts as power-on)
  input  wire logic                sys_clk,
  input  wire logic                sys_rst,
  // External pins and oscillator
  input  wire logic                master_clear_pin_n,
  input  wire logic                wdt_rc_tick,
  output logic                     divided_clock_output,
  output logic                     divided_clock_output_en,
  // Core side
  output logic                     core_reset,
  output logic [PC_WIDTH-1:0]      reset_vector,
  output logic                     sleeping,
  output logic                     code_protect,
  output logic [1:0]               osc_type,
  // Register port
  input  wire reg_req_t            req,
  output logic [11:0]              rdata,
  // Interrupt
  output logic                     irq
);

  // Two-stage synchronisers; first stage is read only by the second
  logic master_clear_pin_s1_q, master_clear_pin_s2_q, tick_s1_q, tick_s2_q, tick_s3_q;
  always_ff @(posedge sys_clk) begin
    master_clear_pin_s1_q <= master_clear_pin_n;  // R16
    master_clear_pin_s2_q <= master_clear_pin_s1_q;
    tick_s1_q <= wdt_rc_tick;  // R08
    tick_s2_q <= tick_s1_q;
    tick_s3_q <= tick_s2_q;
  end

  logic master_clear_pin_active;
  logic wdt_tick;
  assign master_clear_pin_active = ~master_clear_pin_s2_q;  // R14
  assign wdt_tick    = tick_s2_q & ~tick_s3_q;  // R08

  // Pin low is one event at its first cycle; holding it only stretches the hold,
  // so a wake is not followed by a run-reset record on the next cycle
  logic master_clear_pin_prev_q;
  logic master_clear_pin_new;
  always_ff @(posedge sys_clk) begin
    master_clear_pin_prev_q <= master_clear_pin_active;
  end
  assign master_clear_pin_new = master_clear_pin_active & ~master_clear_pin_prev_q;  // R01

  // Configuration word fields; unimplemented bits always read one
  logic [11:0] cfg_word;
  logic        wdt_enabled;
  assign cfg_word    = {CFG_UNIMPL_FILL, CONFIG_WORD[3:0]};  // R11
  assign wdt_enabled = cfg_word[CFG_WATCHDOG_ENABLE_BIT_BIT];  // R07

  // Control state
  logic        sleep_q;
  logic        in_reset_q;
  logic [31:0] delay_cnt_q;
  logic [31:0] wdt_cnt_q;
  logic        wdt_timeout;
  logic        wr_ctrl;
  assign wr_ctrl = req.wr && (req.addr == CTRL_OFFSET);

  // Watchdog counts RC ticks only; no run-time control stops it
  assign wdt_timeout = wdt_enabled && wdt_tick && (wdt_cnt_q == 32'(WDT_TICKS - 1));
  always_ff @(posedge sys_clk) begin
    if (sys_rst || in_reset_q || !wdt_enabled) begin
      wdt_cnt_q <= 32'h0;  // R07
    end else if (wr_ctrl && req.wdata[1]) begin
      wdt_cnt_q <= 32'h0;
    end else if (wdt_tick) begin
      wdt_cnt_q <= wdt_timeout ? 32'h0 : wdt_cnt_q + 32'h1;  // R08
    end
  end

  // Reset event classification; pin wins over watchdog in same cycle
  logic        event_any;
  reset_cause_t cause;
  always_comb begin
    event_any = 1'b0;
    cause     = CAUSE_MASTER_CLEAR_PIN_RUN;
    if (master_clear_pin_new) begin
      event_any = 1'b1;
      cause     = sleep_q ? CAUSE_MASTER_CLEAR_PIN_WAKE : CAUSE_MASTER_CLEAR_PIN_RUN;  // R01
    end else if (wdt_timeout) begin
      event_any = 1'b1;
      cause     = sleep_q ? CAUSE_WDT_WAKE : CAUSE_WDT_RUN;  // R01
    end
  end

  // Sleep: entered by software, left only through a reset event
  always_ff @(posedge sys_clk) begin
    if (sys_rst || event_any) begin
      sleep_q <= 1'b0;  // R13 R03
    end else if (wr_ctrl && req.wdata[0] && !in_reset_q) begin
      sleep_q <= 1'b1;
    end
  end

  // Startup delay: restarted by any event, pin held low keeps it loaded
  always_ff @(posedge sys_clk) begin
    if (sys_rst || event_any || master_clear_pin_active) begin
      in_reset_q  <= 1'b1;  // R09 R03
      delay_cnt_q <= 32'h0;
    end else if (in_reset_q) begin
      if (delay_cnt_q == 32'(STARTUP_COUNT - 1)) begin
        in_reset_q <= 1'b0;  // R16
      end else begin
        delay_cnt_q <= delay_cnt_q + 32'h1;  // R09
      end
    end
  end

  // Status register: page and cause flags; arithmetic bits kept
  logic [7:0] status_q;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      status_q[7:STATUS_PAGE_LSB] <= PAGE_RESET;  // R06
      status_q[STATUS_TO_BIT]     <= 1'b1;  // R02
      status_q[STATUS_PD_BIT]     <= 1'b1;
      status_q[2:0]               <= 3'h0;  // Undefined on power-on; zero chosen
    end else if (event_any) begin
      status_q[7:STATUS_PAGE_LSB] <= PAGE_RESET;  // R05 R06
      case (cause)
        CAUSE_MASTER_CLEAR_PIN_WAKE: status_q[4:3] <= 2'h2;  // R02
        CAUSE_WDT_RUN:   status_q[4:3] <= 2'h1;
        CAUSE_WDT_WAKE:  status_q[4:3] <= 2'h0;
        default:         status_q[4:3] <= status_q[4:3];  // Pin in run: unchanged
      endcase
    end else if (req.wr && req.addr == STATUS_OFFSET && !in_reset_q) begin
      status_q[7:STATUS_PAGE_LSB] <= req.wdata[7:STATUS_PAGE_LSB];
      status_q[2:0]               <= req.wdata[2:0];  // R17
    end
  end

  // Reset-independent scratch byte: untouched by any non-power-on reset
  logic [7:0] keep_q;
  always_ff @(posedge sys_clk) begin
    if (req.wr && req.addr == CAUSE_OFFSET + 8'h10) begin
      keep_q <= req.wdata[7:0];  // R04
    end
  end

  // Sticky event bits and mask; set wins over write-one-clear
  logic [EV_WIDTH-1:0] ev_set;
  logic [EV_WIDTH-1:0] ev_q;
  logic [EV_WIDTH-1:0] mask_q;
  always_comb begin
    ev_set = '0;
    if (event_any) begin
      case (cause)
        CAUSE_MASTER_CLEAR_PIN_RUN:  ev_set[EV_MASTER_CLEAR_PIN_RUN]  = 1'b1;
        CAUSE_MASTER_CLEAR_PIN_WAKE: ev_set[EV_MASTER_CLEAR_PIN_WAKE] = 1'b1;
        CAUSE_WDT_RUN:   ev_set[EV_WDT_RUN]   = 1'b1;
        CAUSE_WDT_WAKE:  ev_set[EV_WDT_WAKE]  = 1'b1;
        default:         ev_set[EV_POR]       = 1'b1;
      endcase
    end
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ev_q <= 5'h01;  // Power-on recorded
    end else if (req.wr && req.addr == CAUSE_OFFSET) begin
      ev_q <= (ev_q & ~req.wdata[EV_WIDTH-1:0]) | ev_set;
    end else begin
      ev_q <= ev_q | ev_set;  // R01
    end
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mask_q <= 5'h00;
    end else if (req.wr && req.addr == MASK_OFFSET) begin
      mask_q <= req.wdata[EV_WIDTH-1:0];
    end
  end

  // Read data: one cycle after the strobe, zero for unmapped addresses
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata <= 12'h000;
    end else if (req.rd) begin
      case (req.addr)
        STATUS_OFFSET:          rdata <= {4'h0, status_q};  // R17
        CONFIG_OFFSET:          rdata <= cfg_word;  // R11
        CAUSE_OFFSET:           rdata <= {7'h00, ev_q};
        MASK_OFFSET:            rdata <= {7'h00, mask_q};
        CTRL_OFFSET:            rdata <= {10'h000, in_reset_q, sleep_q};
        CAUSE_OFFSET + 8'h10:   rdata <= {4'h0, keep_q};
        default:                rdata <= 12'h000;
      endcase
    end else begin
      rdata <= 12'h000;
    end
  end

  // Divide-by-four clock out, only in RC oscillator mode
  logic [1:0] div_q;
  logic       rc_mode;
  assign rc_mode = (cfg_word[1:0] == OSC_RESISTOR_CAPACITOR);  // R10
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      div_q                   <= 2'h0;
      divided_clock_output    <= 1'b0;
      divided_clock_output_en <= 1'b0;
    end else begin
      div_q                   <= div_q + 2'h1;  // R12
      divided_clock_output    <= rc_mode & div_q[1];  // High two of four cycles
      divided_clock_output_en <= rc_mode;  // R12
    end
  end

  // Registered core-side outputs
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      core_reset   <= 1'b1;
      reset_vector <= '1;
      sleeping     <= 1'b0;
      code_protect <= 1'b1;
      osc_type     <= 2'h3;
      irq          <= 1'b0;
    end else begin
      core_reset   <= in_reset_q;  // R09
      reset_vector <= '1;  // R15
      sleeping     <= sleep_q;
      code_protect <= cfg_word[CFG_CP_BIT];  // R11
      osc_type     <= cfg_word[1:0];  // R10
      irq          <= |(ev_q & mask_q);
    end
  end

endmodule
`default_nettype wire

// >>> verification/ext_pins.sv
`timescale 1ns/100ps
`default_nettype none
module ext_pins (
  // System clock for pin timing
  input wire logic  sys_clk,
  // Pin and watchdog clock toward the device
  output var logic  master_clear_pin_n,
  output var logic  wdt_rc_tick
);
  logic tick_on = 1'b0;
  // Pull-up keeps the pin high while nobody pulls it
  initial master_clear_pin_n = 1'b1;
  initial wdt_rc_tick = 1'b0;
  // Own RC clock, unrelated in phase, standing low while off
  always begin
    #85.3;
    wdt_rc_tick = tick_on ? !wdt_rc_tick : 1'b0;
  end
  // Pull the pin low for some cycles to reset or wake
  task automatic pull_low(input int n);
    @(posedge sys_clk);
    master_clear_pin_n <= 1'b0;
    repeat (n) @(posedge sys_clk);
    master_clear_pin_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> verification/rst_ctl_chk.sv
`timescale 1ns/100ps
`default_nettype none
module rst_ctl_chk
  import rst_ctl_pkg::*;
#(
  parameter int          STARTUP_COUNT = 20,
  parameter int          PC_WIDTH      = 11,
  parameter logic [11:0] CONFIG_WORD   = 12'hFFF
) (
  // Clock, reset and pins
  input wire logic                sys_clk,
  input wire logic                sys_rst,
  input wire logic                master_clear_pin_n,
  input wire logic                wdt_rc_tick,
  // Observed outputs and register port
  input wire logic                divided_clock_output,
  input wire logic                divided_clock_output_en,
  input wire logic                core_reset,
  input wire logic [PC_WIDTH-1:0] reset_vector,
  input wire logic                sleeping,
  input wire logic                code_protect,
  input wire logic [1:0]          osc_type,
  input wire reg_req_t            req,
  input wire logic [11:0]         rdata
);
  int         hold_q;
  logic [3:0] quiet_q;
  // Length of the current core hold; pin held low may stretch it a little
  always_ff @(posedge sys_clk) begin
    hold_q <= (sys_rst || !core_reset) ? 0 : hold_q + 1;
  end
  // Cycles with no wake source present, saturating
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !master_clear_pin_n || wdt_rc_tick) quiet_q <= 4'h0;
    else if (quiet_q != 4'hF) quiet_q <= quiet_q + 4'h1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence pin_wake_s;
    sleeping && $fell(master_clear_pin_n);
  endsequence
  sequence full_reset_s;
    !sleeping && core_reset;
  endsequence
  a_config_read: assert property (
    req.rd && req.addr == CONFIG_OFFSET |=> rdata == {8'hFF, CONFIG_WORD[3:0]})
    else $error("config word readback wrong");
  a_config_pins: assert property (
    !$past(sys_rst) |-> osc_type == CONFIG_WORD[1:0] && code_protect == CONFIG_WORD[3])
    else $error("oscillator type or protect pin wrong");
  a_vector_top: assert property (reset_vector == {PC_WIDTH{1'b1}})
    else $error("reset vector not top of memory");
  a_clkout_rate: assert property (
    $rose(divided_clock_output) |-> ##4 $rose(divided_clock_output))
    else $error("divided clock period not four");
  a_clkout_quiet: assert property (!divided_clock_output_en |-> !divided_clock_output)
    else $error("divided clock toggles while not driven");
  a_startup_hold: assert property ($rose(core_reset) |-> core_reset [*8])
    else $error("core released too early");
  a_startup_bound: assert property (hold_q <= STARTUP_COUNT + 8)
    else $error("core held too long");
  a_pin_wake: assert property (pin_wake_s |-> ##[2:6] full_reset_s)
    else $error("pin wake did not reset");
  a_run_reset: assert property (
    !sleeping && !core_reset && $fell(master_clear_pin_n) |-> ##[2:6] core_reset)
    else $error("pin reset in run missing");
  a_sleep_kept: assert property (sleeping && quiet_q > 4'h6 |=> sleeping)
    else $error("sleep left without wake source");
endmodule
bind reset_cause_and_config_control rst_ctl_chk #(
  .STARTUP_COUNT(STARTUP_COUNT), .PC_WIDTH(PC_WIDTH), .CONFIG_WORD(CONFIG_WORD)
) chk (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .master_clear_pin_n(master_clear_pin_n),
  .wdt_rc_tick(wdt_rc_tick), .divided_clock_output(divided_clock_output),
  .divided_clock_output_en(divided_clock_output_en), .core_reset(core_reset),
  .reset_vector(reset_vector), .sleeping(sleeping), .code_protect(code_protect),
  .osc_type(osc_type), .req(req), .rdata(rdata)
);
`default_nettype wire

// >>> verification/tb_reset_cause_and_config_control.sv
`timescale 1ns/100ps
`default_nettype none
module tb_reset_cause_and_config_control;
  import rst_ctl_pkg::*;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  reg_req_t    req = '0;
  logic        pin_n, tick, dclk, dclk_en, core_reset, sleeping, code_protect, irq;
  logic [10:0] reset_vector;
  logic [1:0]  osc_type;
  logic [11:0] rdata;
  int          miscompares = 0;
  int          checked = 0;
  logic [11:0] exp_st [4] = '{12'h005, 12'h005, 12'h015, 12'h00D};
  logic [11:0] exp_ev [4] = '{12'h010, 12'h002, 12'h004, 12'h008};
  logic [3:0]  sl = 4'b0101;
  logic [3:0]  by_pin = 4'b0110;
  // 25 MHz clock
  always #20 sys_clk = !sys_clk;
  ext_pins ext (.sys_clk(sys_clk), .master_clear_pin_n(pin_n), .wdt_rc_tick(tick));
  // Short start-up and watchdog counts; RC mode, watchdog on, unprotected
  reset_cause_and_config_control #(.STARTUP_COUNT(20), .WDT_TICKS(4), .CONFIG_WORD(12'hFF7))
  uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .master_clear_pin_n(pin_n), .wdt_rc_tick(tick),
    .divided_clock_output(dclk), .divided_clock_output_en(dclk_en), .core_reset(core_reset),
    .reset_vector(reset_vector), .sleeping(sleeping), .code_protect(code_protect),
    .osc_type(osc_type), .req(req), .rdata(rdata), .irq(irq));
  task automatic cmp(input string what, input logic [11:0] exp, input logic [11:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [11:0] d);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [11:0] exp, input string what);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: 12'h000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1;
    cmp(what, exp, rdata);
  endtask
  // Bounded wait for the core hold to reach a level
  task automatic hold_until(input logic v);
    int n;
    for (n = 0; n < 200 && core_reset !== v; n++) @(posedge sys_clk);
    if (n == 200) cmp("core_reset", {11'h0, v}, {11'h0, core_reset});
  endtask
  task automatic give_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Whole run is under the 5000-cycle limit set here
  initial begin
    #200_000;
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(STATUS_OFFSET, 12'h018, "status after power-on");
    rd(CAUSE_OFFSET, 12'h001, "power-on event");
    rd(CONFIG_OFFSET, 12'hFF7, "config word");
    cmp("osc and protect", 12'h006, {9'h0, osc_type, code_protect});
    cmp("reset vector", 12'h7FF, {1'b0, reset_vector});
    cmp("clock out enable", 12'h001, {11'h0, dclk_en});
    hold_until(1'b0);
    wr(STATUS_OFFSET, 12'h0E5);
    rd(STATUS_OFFSET, 12'h0FD, "status write");
    wr(8'h21, 12'h0A5);
    wr(MASK_OFFSET, 12'h002);
    // Each pin and watchdog reset kind in turn; only the unmasked pin-run event raises irq
    for (int i = 0; i < 4; i++) begin
      wr(CAUSE_OFFSET, 12'h01F);
      if (sl[i]) begin
        wr(CTRL_OFFSET, 12'h001);
        repeat (10) @(posedge sys_clk);
        cmp("sleeping", 12'h001, {11'h0, sleeping});
      end
      if (by_pin[i]) ext.pull_low(3);
      else ext.tick_on = 1'b1;
      hold_until(1'b1);
      ext.tick_on = 1'b0;
      hold_until(1'b0);
      rd(STATUS_OFFSET, exp_st[i], "status cause flags");
      rd(CAUSE_OFFSET, exp_ev[i], "event bits");
      cmp("sleeping", 12'h000, {11'h0, sleeping});
      cmp("irq", {11'h0, i == 1}, {11'h0, irq});
    end
    wr(CAUSE_OFFSET, 12'h01F);
    rd(CAUSE_OFFSET, 12'h000, "events cleared");
    cmp("irq", 12'h000, {11'h0, irq});
    rd(8'h21, 12'h0A5, "reset independent");
    wr(CONFIG_OFFSET, 12'h000);
    rd(CONFIG_OFFSET, 12'hFF7, "config read only");
    wr(STATUS_OFFSET, 12'h000);
    rd(STATUS_OFFSET, 12'h008, "cause flags kept");
    rd(8'h30, 12'h000, "unmapped read");
    give_verdict();
  end
endmodule
`default_nettype wire
